// file: logic/bay_led_pkg.sv
// constants and carrier types for the bay led / presence stream logic
// assumes a 100 MHz system clock and a slow serial link clock sampled by it
package bay_led_pkg;

  // ----------------------------------------------------------------------
  // stream geometry
  // ----------------------------------------------------------------------
  localparam int BITS_PER_SLOT   = 3;
  localparam int SLOTS_PER_GROUP = 4;
  localparam int BITS_PER_GROUP  = 12;
  localparam int SHORT_LAST_BIT  = 11;
  localparam int LONG_LAST_BIT   = 191;
  localparam int BIT_ACT         = 0;
  localparam int BIT_LOC         = 1;
  localparam int BIT_ERR         = 2;
  localparam int BIT_ABSENT      = 0;
  localparam int BIT_NO_BAY      = 1;
  localparam int BIT_SPARE       = 2;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int BLINK_HZ        = 1;
  localparam int BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);

  // per-bay software status
  typedef struct packed {
    logic active;   // activity / rebuild indication
    logic selected; // locate request
    logic failed;
    logic predict;  // predicted failure
  } bay_status_t;

  // per-bay status returned from the backplane
  typedef struct packed {
    logic absent_n_drive; // 1 = no drive installed
    logic no_bay;         // 1 = bay does not exist
  } bay_presence_t;

endpackage

// file: logic/bay_led_slot.sv
// one bay slot: turns software status and presence into three led bits
// assumes blink_phase toggles every half second on the same clock
`timescale 1ns/1ps
module bay_led_slot
  import bay_led_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  bay_led_pkg::bay_status_t status,
  input  wire logic        no_bay,
  input  wire logic        blink_phase,
  output logic [2:0]       led_q
);

  logic [2:0] led_d;

  // ----------------------------------------------------------------------
  // led pattern selection
  // ----------------------------------------------------------------------
  always_comb
  begin
    led_d          = 3'h0;
    led_d[BIT_ACT] = status.active;
    if (status.selected && (status.failed || status.predict))
    begin
      led_d[BIT_LOC] = blink_phase;
      led_d[BIT_ERR] = ~blink_phase;
    end
    else
    begin
      led_d[BIT_LOC] = status.selected;
      if (status.failed)
        led_d[BIT_ERR] = 1'b1;
      else
        led_d[BIT_ERR] = status.predict & blink_phase;
    end
    // a missing bay is driven all ones so the line floats high
    if (no_bay)
      led_d = 3'h7;
  end

  // registered so the stream sees stable bits
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      led_q <= 3'h7;
    else
      led_q <= led_d;
  end

endmodule

// file: logic/bay_led_presence_map.sv
// bay led and presence map over the serial gpio sideband link
// assumes sclock/sload/sdata_in arrive asynchronously from the pins
`timescale 1ns/1ps
module bay_led_presence_map
  import bay_led_pkg::*;
#(
  parameter int GROUPS     = 4,
  parameter int BLINK_HALF = bay_led_pkg::BLINK_HALF_CYC
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    sclock,
  input  wire logic                    sload,
  input  wire logic                    sdata_in,
  input  wire logic                    sata_known,
  input  bay_led_pkg::bay_status_t [4*GROUPS-1:0] bay_status,
  output logic                         sdata_out,
  output logic                         frame_done,
  output logic [191:0]                 rx_bits,
  output bay_led_pkg::bay_presence_t [4*GROUPS-1:0] presence,
  output logic [1:0]                   bay_group_code [GROUPS],
  output logic                         bay_order [GROUPS],
  output logic                         spare_bit [GROUPS],
  output logic [4:0]                   bay_number [4*GROUPS]
);

  localparam int NBAYS = 4 * GROUPS;

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  initial
  begin
    if (GROUPS < 1 || GROUPS > 4)
      $error("GROUPS must be 1 to 4");
    if (BLINK_HALF < 2)
      $error("BLINK_HALF too small");
  end

  // bay number from code and relative index
  function automatic logic [4:0] bay_num(input logic [1:0] code,
                                         input logic       a_low,
                                         input logic [1:0] rel);
    logic [1:0] idx;
    logic [4:0] base;
    idx  = a_low ? rel : 2'h3 - rel;
    base = {1'b0, ~code, 2'h0};
    return 5'(base + 5'(idx) + 5'h1);
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------------------------------------
  logic [1:0] sck_s_q, sld_s_q, sdi_s_q;
  logic       sck_prev_q;
  logic       sck_rise, sck_fall;

  // the link clock idles high, so the sampler resets high as well;
  // a low reset value would show a false rise just after reset
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_s_q    <= 2'h3;
      sld_s_q    <= 2'h0;
      sdi_s_q    <= 2'h3;
      sck_prev_q <= 1'b1;
    end
    else
    begin
      sck_s_q    <= {sck_s_q[0], sclock};
      sld_s_q    <= {sld_s_q[0], sload};
      sdi_s_q    <= {sdi_s_q[0], sdata_in};
      sck_prev_q <= sck_s_q[1];
    end
  end

  assign sck_rise = sck_s_q[1] & ~sck_prev_q;
  assign sck_fall = ~sck_s_q[1] & sck_prev_q;

  // ----------------------------------------------------------------------
  // half-second blink enable
  // ----------------------------------------------------------------------
  logic [31:0] blink_cnt_q;
  logic        blink_q;

  // one counter shared by all bays keeps every blinking led in phase except the error led of a selected bay with failed or predict set, which is inverted
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end
    else if (blink_cnt_q == 32'(BLINK_HALF - 1))
    begin
      blink_cnt_q <= 32'h0;
      blink_q     <= ~blink_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 32'h1;
  end

  // ----------------------------------------------------------------------
  // per-bay led bits
  // ----------------------------------------------------------------------
  logic [2:0] led [NBAYS];

  for (genvar b = 0; b < NBAYS; b++)
  begin : g_slot
    bay_led_slot u_slot (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .status      (bay_status[b]),
      .no_bay      (presence[b].no_bay),
      .blink_phase (blink_q),
      .led_q       (led[b])
    );
  end

  // ----------------------------------------------------------------------
  // bit position and stream length
  // ----------------------------------------------------------------------
  logic [7:0] pos_q;
  logic [7:0] last_bit;
  logic [5:0] slot;
  logic [1:0] sub;
  logic       in_map;

  // a small map is not repeated up to the long length; unmapped bits
  // are sent as ones, the tristate value
  assign last_bit = sata_known ? 8'(LONG_LAST_BIT)
                               : 8'(SHORT_LAST_BIT);
  assign slot     = 6'(pos_q / BITS_PER_SLOT);
  assign sub      = 2'(pos_q % BITS_PER_SLOT);
  assign in_map   = slot < 6'(NBAYS);

  // sload high at a rising clock restarts the stream; the next rise is bit 0
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pos_q      <= 8'h0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= 1'b0;
      if (sck_rise)
      begin
        if (sld_s_q[1] || pos_q == last_bit)
        begin
          pos_q      <= 8'h0;
          frame_done <= (pos_q == last_bit);
        end
        else
          pos_q <= pos_q + 8'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit: change data on the falling clock edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      sdata_out <= 1'b1;
    else if (sck_fall)
    begin
      if (in_map)
        sdata_out <= led[slot[3:0]][sub];
      else
        sdata_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // receive: capture raw bits on the rising clock edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rx_bits <= {192{1'b1}};
    else if (sck_rise)
      rx_bits[pos_q] <= sdi_s_q[1];
  end

  // ----------------------------------------------------------------------
  // decode the received stream once per completed frame
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int b = 0; b < NBAYS; b++)
      begin
        presence[b]   <= '1;
        bay_number[b] <= 5'h0;
      end
      for (int g = 0; g < GROUPS; g++)
      begin
        bay_group_code[g] <= 2'h0;
        bay_order[g]      <= 1'b0;
        spare_bit[g]      <= 1'b1;
      end
    end
    else if (frame_done)
    begin
      for (int g = 0; g < GROUPS; g++)
      begin
        bay_group_code[g] <= {rx_bits[12*g + BIT_SPARE],
                              rx_bits[12*g + 3 + BIT_SPARE]};
        bay_order[g]      <= rx_bits[12*g + 6 + BIT_SPARE];
        spare_bit[g]      <= rx_bits[12*g + 9 + BIT_SPARE];
        for (int r = 0; r < SLOTS_PER_GROUP; r++)
        begin
          // drive flag is only meaningful when the bay exists
          presence[4*g+r].no_bay <= rx_bits[12*g + 3*r + BIT_NO_BAY];
          presence[4*g+r].absent_n_drive <=
            rx_bits[12*g + 3*r + BIT_ABSENT] |
            rx_bits[12*g + 3*r + BIT_NO_BAY];
          bay_number[4*g+r] <= bay_num(
            {rx_bits[12*g + BIT_SPARE], rx_bits[12*g + 3 + BIT_SPARE]},
            rx_bits[12*g + 6 + BIT_SPARE], 2'(r));
        end
      end
    end
  end

endmodule

// file: tb/bay_led_presence_map_asserts.sv
// checker for the bay led / presence map top module ports
// assumes the link clock idles high and frames start with sload
`timescale 1ns/1ps
module bay_led_presence_map_asserts
  import bay_led_pkg::*;
#(
  parameter int GROUPS = 4
)
(
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  input wire logic                        sclock,
  input wire logic                        sload,
  input wire logic                        sata_known,
  input wire logic                        sdata_out,
  input wire logic                        frame_done,
  input wire logic [191:0]                rx_bits,
  input bay_led_pkg::bay_presence_t [4*GROUPS-1:0] presence,
  input wire logic [1:0]                  bay_group_code [GROUPS],
  input wire logic                        bay_order [GROUPS],
  input wire logic                        spare_bit [GROUPS],
  input wire logic [4:0]                  bay_number [4*GROUPS]
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic       sclk_q;
  logic [7:0] rise_q;
  // counts data rises per frame; the sload rise only restarts
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      sclk_q <= 1'b1;
      rise_q <= 8'h00;
    end
    else
    begin
      sclk_q <= sclock;
      if (frame_done)
        rise_q <= 8'h00;
      else if (sclock && !sclk_q && !sload)
        rise_q <= rise_q + 8'h01;
    end
  sequence s_done;
    frame_done ##1 1'b1;
  endsequence
  property p_len;
    frame_done |-> rise_q == (sata_known ? 8'hC0 : 8'h0C);
  endproperty
  a_len: assert property (p_len) else $error("frame length off");
  property p_pulse;
    frame_done |=> !frame_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_code;
    s_done |-> bay_group_code[0] == {rx_bits[2], rx_bits[5]};
  endproperty
  a_code: assert property (p_code) else $error("group code");
  property p_order;
    s_done |-> bay_order[0] == rx_bits[8];
  endproperty
  a_order: assert property (p_order) else $error("order flag");
  property p_spare;
    s_done |-> spare_bit[0] == rx_bits[11];
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit");
  property p_pres;
    s_done |-> presence[0] == {rx_bits[0] | rx_bits[1], rx_bits[1]};
  endproperty
  a_pres: assert property (p_pres) else $error("presence");
  property p_num;
    s_done |-> bay_number[0] == (bay_order[0] ? 5'h01 : 5'h04)
      + {1'b0, ~bay_group_code[0], 2'b00};
  endproperty
  a_num: assert property (p_num) else $error("bay number");
  property p_stable;
    sclock [*5] |-> $stable(sdata_out);
  endproperty
  a_stable: assert property (p_stable) else $error("out moved");
endmodule

bind bay_led_presence_map bay_led_presence_map_asserts #(.GROUPS(GROUPS))
  u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclock(sclock),
  .sload(sload), .sata_known(sata_known), .sdata_out(sdata_out),
  .frame_done(frame_done), .rx_bits(rx_bits), .presence(presence),
  .bay_group_code(bay_group_code), .bay_order(bay_order),
  .spare_bit(spare_bit), .bay_number(bay_number));

// file: tb/backplane_model.sv
// backplane target: makes the link clock, returns presence bits
// assumes sixteen bays; clock stands high between frames
`timescale 1ns/1ps
module backplane_model
  import bay_led_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sdata_out,
  output logic      sclock,
  output logic      sload,
  output logic      sdata_in
);
  logic         drive_in [16];
  logic         bay_ok   [16];
  logic [1:0]   code     [4];
  logic         order    [4];
  logic         spare    [4];
  logic [191:0] out_q;
  initial
  begin
    sclock = 1'b1;
    sload = 1'b0;
    sdata_in = 1'b1;
  end
  // bit k of the returned stream, slot k/3, sub k%3
  function automatic logic in_bit(input int k);
    int s;
    s = k / 3;
    if (s >= 16)
      return k[0];
    if (k % 3 == 0)
      return !bay_ok[s] || !drive_in[s];
    if (k % 3 == 1)
      return !bay_ok[s];
    case (s % 4)
      0: return code[s/4][1];
      1: return code[s/4][0];
      2: return order[s/4];
      default: return spare[s/4];
    endcase
  endfunction
  task automatic half();
    repeat (8) @(negedge clk_sys);
  endtask
  // one frame: sload rise, then len data bits
  task automatic frame(input int len);
    sload = 1'b1;
    sclock = 1'b0;
    half();
    sclock = 1'b1;
    half();
    for (int k = 0; k < len; k++)
    begin
      sclock = 1'b0;
      sload = 1'b0;
      sdata_in = in_bit(k);
      half();
      out_q[k] = sdata_out;
      sclock = 1'b1;
      half();
    end
    sdata_in = !sdata_in; // released line must not look held
  endtask
endmodule

// file: tb/bay_led_presence_map_bench.sv
// testbench for the bay led / presence map
// assumes the backplane model and the bound checker
`timescale 1ns/1ps
module bay_led_presence_map_bench;
  import bay_led_pkg::*;
  logic clk_sys, sys_rst, sclock, sload, sdata_in, sata_known;
  logic sdata_out, frame_done;
  logic [191:0] rx_bits;
  bay_status_t [15:0] bay_status;
  bay_presence_t [15:0] presence;
  logic [1:0] bay_group_code [4];
  logic bay_order [4];
  logic spare_bit [4];
  logic [4:0] bay_number [16];
  int bad_count, comparisons, base;
  logic [3:0] seen;
  bay_led_presence_map #(.GROUPS(4), .BLINK_HALF(200)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclock(sclock),
    .sload(sload), .sdata_in(sdata_in), .sata_known(sata_known),
    .bay_status(bay_status), .sdata_out(sdata_out),
    .frame_done(frame_done), .rx_bits(rx_bits), .presence(presence),
    .bay_group_code(bay_group_code), .bay_order(bay_order),
    .spare_bit(spare_bit), .bay_number(bay_number));
  backplane_model u_bp (.clk_sys(clk_sys), .sdata_out(sdata_out),
    .sclock(sclock), .sload(sload), .sdata_in(sdata_in));
  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // watchdog: the tests need about 95 us, well under the 300 us limit
  initial
  begin
    #300000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    sys_rst = 1'b1;
    sata_known = 1'b0;
    bay_status = '0;
    for (int i = 0; i < 16; i++)
    begin
      u_bp.drive_in[i] = 1'b0;
      u_bp.bay_ok[i] = 1'b1;
      u_bp.code[i/4] = 2'b00;
      u_bp.order[i/4] = 1'b0;
      u_bp.spare[i/4] = 1'b1;
    end
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    // every group code and order on the first group
    for (int c = 0; c < 4; c++)
      for (int o = 0; o < 2; o++)
      begin
        u_bp.code[0] = c[1:0];
        u_bp.order[0] = o[0];
        u_bp.frame(12);
        base = 13 - 4 * c;
        chk("num_a", 8'(bay_number[0]), 8'(o ? base : base + 3));
        chk("num_d", 8'(bay_number[3]), 8'(o ? base + 3 : base));
      end
    // absent bay, locate, failure, spare bit; bay 0 holds a drive
    u_bp.drive_in[0] = 1'b1;
    u_bp.bay_ok[1] = 1'b0;
    u_bp.spare[0] = 1'b0;
    bay_status[0] = 4'b1100;
    bay_status[1] = 4'b0100;
    bay_status[2] = 4'b0010;
    u_bp.frame(12);
    u_bp.frame(12);
    chk("led_a", 8'(u_bp.out_q[2:0]), 8'h03);
    chk("led_b", 8'(u_bp.out_q[5:3]), 8'h07);
    chk("led_c", 8'(u_bp.out_q[8:6]), 8'h04);
    chk("pres_a", 8'(presence[0]), 8'h00);
    chk("pres_b", 8'(presence[1]), 8'h03);
    chk("pres_c", 8'(presence[2]), 8'h02);
    chk("spare", 8'(spare_bit[0]), 8'h00);
    // long stream with the last group reversed; the first long frame
    // brings in presence of the upper groups, the second shows leds
    sata_known = 1'b1;
    u_bp.code[3] = 2'b00;
    u_bp.order[3] = 1'b0;
    bay_status[13] = 4'b1010;
    u_bp.frame(192);
    u_bp.frame(192);
    chk("num_long", 8'(bay_number[12]), 8'h10);
    chk("led_long", 8'(u_bp.out_q[41:39]), 8'h05);
    chk("pres_long", 8'(presence[13]), 8'h02);
    chk("pad_out", 8'(u_bp.out_q[62:60]), 8'h07);
    chk("rx_last", 8'(rx_bits[191:190]), 8'h02);
    // blinking seen in both states over several frames
    sata_known = 1'b0;
    bay_status[0] = 4'b0110;
    bay_status[2] = 4'b0001;
    seen = 4'h0;
    for (int f = 0; f < 6; f++)
    begin
      u_bp.frame(12);
      seen = seen | {u_bp.out_q[1], ~u_bp.out_q[1],
                     u_bp.out_q[8], ~u_bp.out_q[8]};
    end
    chk("blink", 8'(seen), 8'h0F);
    wrap_up();
  end
endmodule
